/* File: logic/dcd_drive_monitor.sv */
// Overview of operation
// - Overload warning flag rises whenever output current exceeds the warning level.
// - Overload warning reaches a terminal only when its function code is 7.
// - Current detected sets after current stays above level longer than the timer.
// - Current detected clears when current drops below 90% of the level.
// - Current detected stays high at least 100 ms once set.
// - Current detected reaches a terminal only when its function code is 37.
// - Command below 10% of sample within 400 ms declares loss; run at fallback ratio.
// - Command back above the recovery level clears loss; follow command again.
// - Ratio 999 still raises loss but leaves the command unchanged.
// - Ratio 0 or 999 uses sampled level times 0.2 as recovery level.
// - Ratio 100% or more, other than 999, uses sampled level times 1 as recovery level.
// - Command level is sampled at regular intervals; latest sample is the reference.
// - Loss detection looks at the unfiltered analog input.
// - Low torque sets after torque stays below level longer than the timer.
// - Low torque clears when torque exceeds level plus 5%.
// - Low torque stays high at least 100 ms once set, unless the drive stops.
// - Low torque reaches a terminal only when its function code is 45.
// - Torque level is in percent, 100 meaning rated motor torque.
// - Below 20% of base frequency low torque evaluation freezes and holds.
// - Low torque flag is forced low while the drive is stopped.
// - Loss flag clears when running from the analog input resumes.
// - Loss flag reaches a terminal only when its function code is 33.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module dcd_drive_monitor #(
    parameter int unsigned TICK_CYCLES = dcd_pkg::TICK_CYCLES
) (
    input  wire logic [dcd_pkg::AW-1:0]    addr,
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire logic [dcd_pkg::DW-1:0]    wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [dcd_pkg::DW-1:0]    rd_data,
    input  wire logic [dcd_pkg::DW-1:0]    current_meas,
    input  wire logic [dcd_pkg::DW-1:0]    torque_meas,
    input  wire logic [dcd_pkg::DW-1:0]    analog_cmd_raw,
    input  wire logic [dcd_pkg::DW-1:0]    output_freq,
    input  wire logic                      drive_running,
    output logic      [dcd_pkg::DW-1:0]    freq_cmd,
    output logic      [dcd_pkg::TERMS-1:0] term_out
);
    import dcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Value times a percentage, kept wide so comparisons never overflow.
    function automatic logic [31:0] pct_of(input logic [15:0] v, input logic [9:0] p);
        pct_of = 32'(v) * 32'(p);
    endfunction

    // Level above which a lost command counts as restored.
    function automatic logic [9:0] recov_pct(input logic [9:0] ratio);
        if (ratio == RATIO_ZERO || ratio == RATIO_DISABLED) begin
            recov_pct = PCT_RECOV_LOW;
        end else if (ratio >= PCT_FULL) begin
            recov_pct = PCT_FULL;
        end else begin
            recov_pct = ratio;
        end
    endfunction

    function automatic logic route(input logic [7:0] sel, input logic [3:0] flags);
        case (sel)
            FN_OVERLOAD: route = flags[ST_OVERLOAD];
            FN_CURRENT:  route = flags[ST_CURRENT];
            FN_LOSS:     route = flags[ST_LOSS];
            FN_LOW_TRQ:  route = flags[ST_LOW_TRQ];
            default:     route = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Settings.
    logic [15:0] cur_level_q;
    logic [15:0] cur_timer_q;
    logic [9:0]  loss_ratio_q;
    logic [15:0] trq_level_q;
    logic [15:0] trq_timer_q;
    logic [15:0] base_freq_q;
    logic [7:0]  term_sel_q [TERMS];
    logic [15:0] rd_data_q;

    // Monitoring state.
    logic        tick;
    logic        overload_q;
    logic        current_detected_flag;
    logic        low_torque_flag;
    logic        loss_q;
    logic [15:0] sampled_command_level_q;
    logic [15:0] window_q;
    logic [15:0] freq_cmd_q;
    logic [TERMS-1:0] term_out_q;
    logic [3:0]  flags;
    logic [31:0] fallback_wide;
    logic        loss_trip;
    logic        loss_clear;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cur_level_q  <= RST_CUR_LEVEL;
            cur_timer_q  <= RST_CUR_TIMER;
            loss_ratio_q <= RST_LOSS_RATIO;
            trq_level_q  <= RST_TRQ_LEVEL;
            trq_timer_q  <= RST_TRQ_TIMER;
            base_freq_q  <= RST_BASE_FREQ;
        end else if (wr_en) begin
            case (addr)
                OFS_CUR_LEVEL:  cur_level_q  <= wr_data;
                OFS_CUR_TIMER:  cur_timer_q  <= wr_data;
                OFS_LOSS_RATIO: loss_ratio_q <= wr_data[9:0];
                OFS_TRQ_LEVEL:  trq_level_q  <= wr_data;
                OFS_TRQ_TIMER:  trq_timer_q  <= wr_data;
                OFS_BASE_FREQ:  base_freq_q  <= wr_data;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < TERMS; i++) begin
            if (reset) begin
                term_sel_q[i] <= RST_TERM_SEL;
            end else if (wr_en && addr == OFS_TERM_SEL + 8'(i)) begin
                term_sel_q[i] <= wr_data[7:0];
            end
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_sys) begin
        if (reset || !rd_en) begin
            rd_data_q <= 16'h0;
        end else begin
            case (addr)
                OFS_CUR_LEVEL:  rd_data_q <= cur_level_q;
                OFS_CUR_TIMER:  rd_data_q <= cur_timer_q;
                OFS_LOSS_RATIO: rd_data_q <= {6'h00, loss_ratio_q};
                OFS_TRQ_LEVEL:  rd_data_q <= trq_level_q;
                OFS_TRQ_TIMER:  rd_data_q <= trq_timer_q;
                OFS_BASE_FREQ:  rd_data_q <= base_freq_q;
                OFS_TERM_SEL:   rd_data_q <= {8'h00, term_sel_q[0]};
                OFS_TERM_SEL + 8'h01: rd_data_q <= {8'h00, term_sel_q[1]};
                OFS_TERM_SEL + 8'h02: rd_data_q <= {8'h00, term_sel_q[2]};
                OFS_STATUS:     rd_data_q <= {12'h000, flags};
                OFS_SAMPLED:    rd_data_q <= sampled_command_level_q;
                default:        rd_data_q <= 16'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Common sampling tick.
    dcd_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (tick)
    );

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overload_q <= 1'b0;
        end else if (tick) begin
            overload_q <= (current_meas > cur_level_q);
        end
    end

    // The overload level doubles as the current detection level.
    dcd_flag_timer u_current (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .tick        (tick),
        .cond_on     (current_meas > cur_level_q),
        .cond_off    (pct_of(current_meas, PCT_FULL)
                      < pct_of(cur_level_q, PCT_CUR_OFF)),
        .freeze      (1'b0),
        .force_clear (1'b0),
        .period      (cur_timer_q),
        .flag        (current_detected_flag)
    );

    // Torque below a fifth of base speed is too inaccurate to judge, so the flag holds.
    dcd_flag_timer u_low_torque (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .tick        (tick),
        .cond_on     (torque_meas < trq_level_q),
        .cond_off    (17'(torque_meas) > 17'(trq_level_q) + 17'(PCT_TRQ_HYST)),
        .freeze      (pct_of(output_freq, PCT_FULL) < pct_of(base_freq_q, PCT_BLANK)),
        .force_clear (!drive_running),
        .period      (trq_timer_q),
        .flag        (low_torque_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Command loss. Works on the raw input, so filter settings cannot hide a break.
    assign loss_trip  = !loss_q && (pct_of(analog_cmd_raw, PCT_FULL)
                        < pct_of(sampled_command_level_q, PCT_LOSS));
    assign loss_clear = loss_q && (pct_of(analog_cmd_raw, PCT_FULL)
                        > pct_of(sampled_command_level_q, recov_pct(loss_ratio_q)));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            loss_q <= 1'b0;
        end else if (tick && loss_trip) begin
            loss_q <= 1'b1;
        end else if (tick && loss_clear) begin
            loss_q <= 1'b0;
        end
    end

    // The reference freezes during loss so recovery is judged against the good level.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            window_q <= 16'h0;
        end else if (tick && (loss_trip || loss_clear
                     || window_q == LOSS_WINDOW_TICKS - 16'h1)) begin
            window_q <= 16'h0;
        end else if (tick && !loss_q) begin
            window_q <= window_q + 16'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sampled_command_level_q <= 16'h0;
        end else if (tick && !loss_trip && !loss_q && window_q == LOSS_WINDOW_TICKS - 16'h1) begin
            sampled_command_level_q <= analog_cmd_raw;
        end else if (tick && loss_clear) begin
            sampled_command_level_q <= analog_cmd_raw;
        end
    end

    assign fallback_wide = pct_of(sampled_command_level_q, loss_ratio_q) / 32'd100;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            freq_cmd_q <= 16'h0;
        end else if (loss_q && loss_ratio_q != RATIO_DISABLED) begin
            freq_cmd_q <= (fallback_wide > 32'h0000ffff) ? 16'hffff
                          : fallback_wide[15:0];
        end else begin
            freq_cmd_q <= analog_cmd_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Terminal routing.
    assign flags = {low_torque_flag, loss_q, current_detected_flag, overload_q};

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < TERMS; i++) begin
            if (reset) begin
                term_out_q[i] <= 1'b0;
            end else begin
                term_out_q[i] <= route(term_sel_q[i], flags);
            end
        end
    end

    assign rd_data  = rd_data_q;
    assign freq_cmd = freq_cmd_q;
    assign term_out = term_out_q;

    ////////////////////////////////////////////////////////////////////////////////
    property p_overload_rise;
        @(posedge clk_sys) disable iff (reset)
        (tick && current_meas > cur_level_q) |=> overload_q;
    endproperty
    a_overload_rise: assert property (p_overload_rise) else $error("overload missed");

    property p_route_ol;
        @(posedge clk_sys) disable iff (reset)
        (term_sel_q[0] == FN_OVERLOAD) |=> (term_out_q[0] == $past(overload_q));
    endproperty
    a_route_ol: assert property (p_route_ol) else $error("overload routing wrong");

    property p_route_cur;
        @(posedge clk_sys) disable iff (reset)
        (term_sel_q[1] == FN_CURRENT) |=> (term_out_q[1] == $past(current_detected_flag));
    endproperty
    a_route_cur: assert property (p_route_cur) else $error("current routing wrong");

    property p_route_trq;
        @(posedge clk_sys) disable iff (reset)
        (term_sel_q[2] == FN_LOW_TRQ) |=> (term_out_q[2] == $past(low_torque_flag));
    endproperty
    a_route_trq: assert property (p_route_trq) else $error("torque routing wrong");

    property p_route_loss;
        @(posedge clk_sys) disable iff (reset)
        (term_sel_q[2] == FN_LOSS) |=> (term_out_q[2] == $past(loss_q));
    endproperty
    a_route_loss: assert property (p_route_loss) else $error("loss routing wrong");

    property p_loss_trip;
        @(posedge clk_sys) disable iff (reset)
        (tick && !loss_q && 32'(analog_cmd_raw) * 32'd10 < 32'(sampled_command_level_q))
            |=> loss_q;
    endproperty
    a_loss_trip: assert property (p_loss_trip) else $error("loss not declared");

    property p_loss_disabled;
        @(posedge clk_sys) disable iff (reset)
        (loss_q && loss_ratio_q == RATIO_DISABLED) |=> (freq_cmd_q == $past(analog_cmd_raw));
    endproperty
    a_loss_disabled: assert property (p_loss_disabled) else $error("command altered");

    property p_recover_low;
        @(posedge clk_sys) disable iff (reset)
        (tick && loss_q && (loss_ratio_q == RATIO_ZERO || loss_ratio_q == RATIO_DISABLED)
            && 32'(analog_cmd_raw) * 32'd5 > 32'(sampled_command_level_q)) |=> !loss_q;
    endproperty
    a_recover_low: assert property (p_recover_low) else $error("no recovery at 0.2");

    property p_sample_frozen;
        @(posedge clk_sys) disable iff (reset)
        (loss_q && !(tick && loss_clear)) |=> $stable(sampled_command_level_q);
    endproperty
    a_sample_frozen: assert property (p_sample_frozen) else $error("reference moved");

    property p_overload_fall;
        @(posedge clk_sys) disable iff (reset)
        (tick && current_meas <= cur_level_q) |=> !overload_q;
    endproperty
    a_overload_fall: assert property (p_overload_fall) else $error("overload stuck");

    property p_fallback_freq;
        @(posedge clk_sys) disable iff (reset)
        (loss_q && loss_ratio_q <= PCT_FULL)
            |=> (pct_of(freq_cmd_q, PCT_FULL)
                    <= pct_of($past(sampled_command_level_q), $past(loss_ratio_q)))
                && (pct_of(freq_cmd_q, PCT_FULL) + 32'd100
                    > pct_of($past(sampled_command_level_q), $past(loss_ratio_q)));
    endproperty
    a_fallback_freq: assert property (p_fallback_freq) else $error("fallback wrong");

    property p_trq_stop;
        @(posedge clk_sys) disable iff (reset)
        (tick && !drive_running) |=> !low_torque_flag;
    endproperty
    a_trq_stop: assert property (p_trq_stop) else $error("low torque kept at stop");

    property p_recover_full;
        @(posedge clk_sys) disable iff (reset)
        (tick && loss_q && loss_ratio_q >= PCT_FULL && loss_ratio_q != RATIO_DISABLED
            && analog_cmd_raw > sampled_command_level_q) |=> !loss_q;
    endproperty
    a_recover_full: assert property (p_recover_full) else $error("no recovery at 1");

    c_loss_rise:  cover property (@(posedge clk_sys) disable iff (reset) $rose(loss_q));
    c_loss_fall:  cover property (@(posedge clk_sys) disable iff (reset) $fell(loss_q));
    c_cur_pulse:  cover property (@(posedge clk_sys) disable iff (reset)
                                  $fell(current_detected_flag));
    c_trq_term:   cover property (@(posedge clk_sys) disable iff (reset) $rose(term_out_q[2]));

endmodule

`default_nettype wire

/* File: logic/dcd_flag_timer.sv */
`timescale 1ns/1ns
`default_nettype none

module dcd_flag_timer
    import dcd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        tick,
    input  wire logic        cond_on,
    input  wire logic        cond_off,
    input  wire logic        freeze,
    input  wire logic        force_clear,
    input  wire logic [15:0] period,
    output logic             flag
);

    logic [15:0] cnt_q;
    logic [15:0] hold_q;
    logic        flag_q;
    logic        fire;
    logic        release_ok;

    assign fire       = !freeze && !flag_q && cond_on && (cnt_q >= period);
    assign release_ok = flag_q && cond_off && (hold_q >= MIN_ON_TICKS);

    ////////////////////////////////////////////////////////////////////////////////
    // Persistence counter; a break in the condition starts it over.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= 16'h0;
        end else if (tick && (force_clear || fire)) begin
            cnt_q <= 16'h0;
        end else if (tick && !freeze && !flag_q) begin
            cnt_q <= cond_on ? cnt_q + 16'h1 : 16'h0;
        end
    end

    // Saturating on-time counter; it runs through a freeze, since the minimum width is real time.
    always_ff @(posedge clk_sys) begin
        if (reset || (tick && (force_clear || fire))) begin
            hold_q <= 16'h0;
        end else if (tick && flag_q && hold_q < MIN_ON_TICKS) begin
            hold_q <= hold_q + 16'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (tick && force_clear) begin
            flag_q <= 1'b0;
        end else if (tick && !freeze && fire) begin
            flag_q <= 1'b1;
        end else if (tick && !freeze && release_ok) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;

    ////////////////////////////////////////////////////////////////////////////////
    property p_min_on;
        @(posedge clk_sys) disable iff (reset)
        $fell(flag_q) |-> ($past(force_clear) || $past(hold_q) >= MIN_ON_TICKS);
    endproperty
    a_min_on: assert property (p_min_on) else $error("flag released too early");

    property p_persist;
        @(posedge clk_sys) disable iff (reset)
        $rose(flag_q) |-> ($past(cnt_q) >= $past(period) && $past(cond_on));
    endproperty
    a_persist: assert property (p_persist) else $error("flag set before period");

    property p_force_clear;
        @(posedge clk_sys) disable iff (reset)
        (tick && force_clear) |=> !flag_q ##1 !flag_q;
    endproperty
    a_force_clear: assert property (p_force_clear) else $error("flag not cleared");

    property p_freeze_hold;
        @(posedge clk_sys) disable iff (reset)
        (tick && freeze && !force_clear) |=> $stable(flag_q);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("flag not held");

endmodule

`default_nettype wire

/* File: logic/dcd_pkg.sv */
`default_nettype none

package dcd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and sampling tick.
    localparam int unsigned CLK_FREQ_MHZ      = 50;
    localparam int unsigned TICK_PERIOD_US    = 1000;
    localparam int unsigned TICK_CYCLES       = CLK_FREQ_MHZ * TICK_PERIOD_US;
    localparam int unsigned MIN_ON_MS         = 100;
    localparam int unsigned LOSS_WINDOW_MS    = 400;
    localparam logic [15:0] MIN_ON_TICKS      = 16'(MIN_ON_MS * 1000 / TICK_PERIOD_US);
    localparam logic [15:0] LOSS_WINDOW_TICKS = 16'(LOSS_WINDOW_MS * 1000 / TICK_PERIOD_US);

    ////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int unsigned DW    = 16;
    localparam int unsigned AW    = 8;
    localparam int unsigned TERMS = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Percentages and special ratio codes.
    localparam logic [9:0] PCT_FULL       = 10'h064;
    localparam logic [9:0] PCT_LOSS       = 10'h00a;
    localparam logic [9:0] PCT_CUR_OFF    = 10'h05a;
    localparam logic [9:0] PCT_TRQ_HYST   = 10'h005;
    localparam logic [9:0] PCT_BLANK      = 10'h014;
    localparam logic [9:0] PCT_RECOV_LOW  = 10'h014;
    localparam logic [9:0] RATIO_DISABLED = 10'h3e7;
    localparam logic [9:0] RATIO_ZERO     = 10'h000;

    ////////////////////////////////////////////////////////////////////////////////
    // Output terminal function codes.
    localparam logic [7:0] FN_OVERLOAD = 8'h07;
    localparam logic [7:0] FN_LOSS     = 8'h21;
    localparam logic [7:0] FN_CURRENT  = 8'h25;
    localparam logic [7:0] FN_LOW_TRQ  = 8'h2d;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] OFS_CUR_LEVEL  = 8'h00;
    localparam logic [7:0] OFS_CUR_TIMER  = 8'h01;
    localparam logic [7:0] OFS_LOSS_RATIO = 8'h02;
    localparam logic [7:0] OFS_TRQ_LEVEL  = 8'h03;
    localparam logic [7:0] OFS_TRQ_TIMER  = 8'h04;
    localparam logic [7:0] OFS_BASE_FREQ  = 8'h05;
    localparam logic [7:0] OFS_TERM_SEL   = 8'h06;
    localparam logic [7:0] OFS_STATUS     = 8'h0a;
    localparam logic [7:0] OFS_SAMPLED    = 8'h0b;

    ////////////////////////////////////////////////////////////////////////////////
    // Status bit positions and reset values.
    localparam int unsigned ST_OVERLOAD = 0;
    localparam int unsigned ST_CURRENT  = 1;
    localparam int unsigned ST_LOSS     = 2;
    localparam int unsigned ST_LOW_TRQ  = 3;

    localparam logic [15:0] RST_CUR_LEVEL  = 16'h0064;
    localparam logic [15:0] RST_CUR_TIMER  = 16'h000a;
    localparam logic [9:0]  RST_LOSS_RATIO = 10'h3e7;
    localparam logic [15:0] RST_TRQ_LEVEL  = 16'h0014;
    localparam logic [15:0] RST_TRQ_TIMER  = 16'h0014;
    localparam logic [15:0] RST_BASE_FREQ  = 16'h0258;
    localparam logic [7:0]  RST_TERM_SEL   = 8'h00;

endpackage

`default_nettype wire

/* File: logic/dcd_tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none

module dcd_tick_gen #(
    parameter int unsigned TICK_CYCLES = 50000
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    output logic      tick
);

    logic [31:0] cnt_q;
    logic        tick_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= 32'h0;
        end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == 32'(TICK_CYCLES - 1));
        end
    end

    assign tick = tick_q;

endmodule

`default_nettype wire

/* File: verif/tb_dcd_drive_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_dcd_drive_monitor;
    import dcd_pkg::*;

    // A short tick keeps the 100 and 400 tick spans affordable in simulation.
    localparam int unsigned TC = 4;

    logic          clk_sys;
    logic          reset;
    logic [AW-1:0] addr;
    logic [DW-1:0] wr_data, rd_data, current_meas, torque_meas, analog_cmd_raw;
    logic [DW-1:0] output_freq, freq_cmd;
    logic          wr_en, rd_en, drive_running;
    logic [TERMS-1:0] term_out;
    int            n_errors, num_checks;

    dcd_drive_monitor #(.TICK_CYCLES(TC)) dut (
        .addr(addr), .clk_sys(clk_sys), .reset(reset), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .current_meas(current_meas),
        .torque_meas(torque_meas), .analog_cmd_raw(analog_cmd_raw),
        .output_freq(output_freq), .drive_running(drive_running),
        .freq_cmd(freq_cmd), .term_out(term_out));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk("rd_data", rd_data, exp);
        // Read data must fall back to zero once their single cycle is over.
        @(posedge clk_sys);
        #1 chk("rd_data idle", rd_data, 16'h0000);
    endtask

    task automatic ticks(input int n);
        repeat (n * TC) @(posedge clk_sys);
        #1;
    endtask

    task automatic term(input int i, input logic e);
        chk("term_out", 16'(term_out[i]), 16'(e));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  ra [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a, 8'h0f};
    logic [15:0] rv [9] = '{16'h0064, 16'h000a, 16'h03e7, 16'h0014, 16'h0014, 16'h0258,
                            16'h0000, 16'h0000, 16'h0000};

    initial begin
        reset = 1'b1;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        current_meas = '0;
        torque_meas = 16'd100;
        analog_cmd_raw = 16'd1000;
        output_freq = 16'd600;
        drive_running = 1'b1;
        n_errors = 0;
        num_checks = 0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        // Unmapped and read-only places are part of the table.
        wr(8'h0a, 16'hffff);
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
        wr(8'h06, 16'h0007);
        wr(8'h07, 16'h0025);
        wr(8'h08, 16'h002d);
        rd(8'h07, 16'h0025);
        // A broken run must restart the persistence count.
        current_meas <= 16'd101;
        ticks(8);
        term(0, 1'b1);
        term(1, 1'b0);
        current_meas <= 16'd50;
        ticks(2);
        current_meas <= 16'd101;
        ticks(8);
        term(1, 1'b0);
        ticks(6);
        term(1, 1'b1);
        current_meas <= 16'd95;
        ticks(3);
        term(0, 1'b0);
        term(1, 1'b1);
        current_meas <= 16'd50;
        ticks(3);
        term(1, 1'b1);
        ticks(100);
        term(1, 1'b0);
        torque_meas <= 16'd10;
        ticks(10);
        term(2, 1'b0);
        ticks(15);
        term(2, 1'b1);
        output_freq <= 16'd100;
        torque_meas <= 16'd50;
        ticks(110);
        term(2, 1'b1);
        output_freq <= 16'd600;
        ticks(3);
        term(2, 1'b0);
        torque_meas <= 16'd10;
        ticks(25);
        torque_meas <= 16'd24;
        ticks(110);
        term(2, 1'b1);
        drive_running <= 1'b0;
        ticks(2);
        term(2, 1'b0);
        drive_running <= 1'b1;
        torque_meas <= 16'd100;
        ticks(410);
        rd(8'h0b, 16'd1000);
        chk("freq_cmd", freq_cmd, 16'd1000);
        wr(8'h08, 16'h0021);
        analog_cmd_raw <= 16'd50;
        ticks(2);
        term(2, 1'b1);
        chk("freq_cmd", freq_cmd, 16'd50);
        analog_cmd_raw <= 16'd150;
        ticks(2);
        term(2, 1'b1);
        analog_cmd_raw <= 16'd250;
        ticks(2);
        term(2, 1'b0);
        chk("freq_cmd", freq_cmd, 16'd250);
        wr(8'h02, 16'd50);
        analog_cmd_raw <= 16'd10;
        ticks(2);
        chk("freq_cmd", freq_cmd, 16'd125);
        rd(8'h0a, 16'h0004);
        wr(8'h02, 16'd120);
        ticks(2);
        chk("freq_cmd", freq_cmd, 16'd300);
        analog_cmd_raw <= 16'd240;
        ticks(2);
        term(2, 1'b1);
        analog_cmd_raw <= 16'd260;
        ticks(2);
        term(2, 1'b0);
        complete_run();
    end

    // The planned sequence needs about 3400 cycles; this bound leaves ample room.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        complete_run();
    end

endmodule

`default_nettype wire
